// >>> rtl/pld_diag.v
// link status, loopback routing, frame generator and checker, test patterns
`timescale 1ns/1ps
`include "pld_diag_map.vh"
module pld_diag #(
  parameter DW = 8,
  parameter CW = 16
) (
  input  wire          clock,
  input  wire          rst_n,
  input  wire          neg_enable,
  input  wire          neg_forced_mode,
  input  wire          neg_restart_req,
  input  wire          neg_exchange_in,
  input  wire          link_ok_in,
  output reg           neg_restart_pulse,
  output reg           neg_exchange_done,
  output reg           neg_done_with_link,
  input  wire          link_status_rd,
  output reg           link_up_latch_low,
  input  wire          soft_power_down,
  input  wire [2:0]    test_pattern_select,
  output reg  [1:0]    tx_symbol,
  output reg           tx_symbol_en,
  input  wire          medium_attach_loop_en,
  input  wire          coding_sublayer_loop_en,
  input  wire          host_side_loop_en,
  input  wire          host_loop_line_quiet,
  input  wire          far_end_loop_en,
  input  wire          far_loop_rx_withhold,
  input  wire          port_loop_en,
  output wire          medium_loop_active,
  output wire          line_drive_en,
  input  wire [DW-1:0] mac_tx_data,
  input  wire          mac_tx_valid,
  input  wire          mac_tx_last,
  output wire          mac_tx_ready,
  output reg  [DW-1:0] host_rx_data,
  output reg           host_rx_valid,
  output reg           host_rx_last,
  input  wire          host_rx_ready,
  input  wire [DW-1:0] phy_rx_data,
  input  wire          phy_rx_valid,
  input  wire          phy_rx_last,
  input  wire          phy_rx_crc_err,
  input  wire [7:0]    phy_rx_err_kinds,
  output wire [DW-1:0] phy_tx_data,
  output wire          phy_tx_valid,
  output wire          phy_tx_last,
  input  wire          phy_tx_ready,
  input  wire          frame_gen_enable,
  input  wire          frame_gen_random,
  input  wire [15:0]   frame_gen_length,
  input  wire [15:0]   frame_gen_count,
  output reg           frame_gen_finished,
  input  wire          frame_chk_enable,
  input  wire          frame_chk_source_sel,
  input  wire          crc_counter_rd,
  output reg  [CW-1:0] crc_error_counter,
  output reg  [CW-1:0] latched_frames_high,
  output reg  [CW-1:0] latched_frames_low,
  output reg  [8*CW-1:0] latched_err_counts
);
  // the exchange and link-ok pins from the outside world pass two flops first
  // two cycles of latency here, one more in the status registers
  reg  [1:0] xo_s1_reg, xo_s2_reg;
  always @(posedge clock)
  begin
    xo_s1_reg <= {neg_exchange_in, link_ok_in};
    xo_s2_reg <= xo_s1_reg;
  end
  wire exch_s = xo_s2_reg[1];
  wire link_s = xo_s2_reg[0];
  reg  link_d_reg;
  // restart pulse lasts one cycle on a link drop, as long as the request otherwise, and masks the done flags in the cycle after it

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      link_d_reg         <= 1'b0;
      neg_restart_pulse  <= 1'b0;
      neg_exchange_done  <= 1'b0;
      neg_done_with_link <= 1'b0;
      link_up_latch_low  <= `PLD_LINK_RST;
    end
    else
    begin
      link_d_reg <= link_s;
      neg_restart_pulse <= neg_enable & (neg_restart_req | (link_d_reg & ~link_s));
      neg_exchange_done  <= neg_enable & exch_s & ~neg_restart_pulse;
      neg_done_with_link <= neg_enable & exch_s & link_s & ~neg_restart_pulse;
      // a failure wins over the read so a drop never hides
      if (!link_s)
        link_up_latch_low <= 1'b0;
      else if (link_status_rd)
        link_up_latch_low <= 1'b1;
    end
  end

  // medium loopback only counts in forced mode without negotiation
  assign medium_loop_active = medium_attach_loop_en & ~neg_enable & neg_forced_mode;
  assign line_drive_en = ~soft_power_down & ~coding_sublayer_loop_en
                       & ~(host_side_loop_en & host_loop_line_quiet);

  // test pattern generator
  // power-down restarts both patterns from their first symbol
  reg [4:0] tm_cnt_reg;
  reg       tm_pol_reg;
  always @(posedge clock)
  begin
    if (!rst_n || soft_power_down)
    begin
      tm_cnt_reg   <= 5'h00;
      tm_pol_reg   <= 1'b0;
      tx_symbol    <= `PLD_SYM_ZERO;
      tx_symbol_en <= 1'b0;
    end
    else
    begin
      tx_symbol_en <= 1'b1;
      case (test_pattern_select)
        `PLD_TM_ONE:
        begin
          tm_pol_reg <= ~tm_pol_reg;
          tx_symbol  <= tm_pol_reg ? `PLD_SYM_MINUS : `PLD_SYM_PLUS;
        end
        `PLD_TM_TWO:
        begin
          if (tm_cnt_reg == `PLD_TM2_RUN - 5'h01)
          begin
            tm_cnt_reg <= 5'h00;
            tm_pol_reg <= ~tm_pol_reg;
          end
          else
            tm_cnt_reg <= tm_cnt_reg + 5'h01;
          tx_symbol <= tm_pol_reg ? `PLD_SYM_MINUS : `PLD_SYM_PLUS;
        end
        `PLD_TM_TXDIS: tx_symbol <= `PLD_SYM_ZERO;
        default:
        begin
          // normal data path: mode three sends ordinary idle, so no override
          tx_symbol_en <= 1'b0;
          tx_symbol    <= `PLD_SYM_ZERO;
        end
      endcase
    end
  end

  // frame generator
  // a frame count of zero finishes at once without sending a word
  localparam GEN_IDLE = 3'b001;
  localparam GEN_SEND = 3'b010;
  localparam GEN_DONE = 3'b100;
  reg [2:0]  gen_state_reg;
  reg [15:0] gen_byte_reg, gen_frame_reg;
  reg [7:0]  lfsr_reg;
  reg        gen_en_d_reg;
  wire gen_last = (gen_byte_reg == frame_gen_length - 16'h0001);
  wire gen_valid = (gen_state_reg == GEN_SEND);
  wire gen_fire  = gen_valid & phy_tx_ready;
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      gen_state_reg <= GEN_IDLE;
      gen_byte_reg <= 16'h0000;
      gen_frame_reg <= 16'h0000;
      lfsr_reg <= 8'h01;
      gen_en_d_reg <= 1'b0;
      frame_gen_finished <= 1'b0;
    end
    else
    begin
      gen_en_d_reg <= frame_gen_enable;
      if (!frame_gen_enable)
      begin
        gen_state_reg <= GEN_IDLE;
        frame_gen_finished <= 1'b0;
      end
      else
        case (gen_state_reg)
          GEN_IDLE:
            if (!gen_en_d_reg)
            begin
              gen_byte_reg <= 16'h0000;
              gen_frame_reg <= 16'h0000;
              frame_gen_finished <= 1'b0;
              gen_state_reg <= (frame_gen_count == 16'h0000) ? GEN_DONE : GEN_SEND;
            end
          GEN_SEND:
            if (gen_fire)
            begin
              lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
              if (gen_last)
              begin
                gen_byte_reg <= 16'h0000;
                gen_frame_reg <= gen_frame_reg + 16'h0001;
                if (gen_frame_reg == frame_gen_count - 16'h0001)
                  gen_state_reg <= GEN_DONE;
              end
              else
                gen_byte_reg <= gen_byte_reg + 16'h0001;
            end
          GEN_DONE: frame_gen_finished <= 1'b1;
          default: gen_state_reg <= GEN_IDLE;
        endcase
    end
  end
  // the byte-wide lfsr is repeated over the word and cut back to DW bits
  wire [8*((DW+7)/8)-1:0] lfsr_rep = {(DW+7)/8{lfsr_reg}};
  wire [DW-1:0]           gen_data = frame_gen_random ? lfsr_rep[DW-1:0] : {DW{1'b1}};

  // transmit path: generator takes precedence over the mac
  // far-end loop has no ready towards the line receiver: a stalled line drops words
  wire mac_to_line = ~frame_gen_enable & ~port_loop_en & ~host_side_loop_en;
  assign phy_tx_valid = frame_gen_enable ? gen_valid :
                        (far_end_loop_en & link_s) ? phy_rx_valid :
                        mac_to_line & mac_tx_valid;
  assign phy_tx_data  = frame_gen_enable ? gen_data :
                        (far_end_loop_en & link_s) ? phy_rx_data : mac_tx_data;
  assign phy_tx_last  = frame_gen_enable ? gen_last :
                        (far_end_loop_en & link_s) ? phy_rx_last : mac_tx_last;

  // two-entry skid buffer towards the host: a host stall loses nothing in the mac-side loops, but line receive words are dropped when full
  reg [DW:0] buf_reg [0:1];
  reg [1:0]  buf_cnt_reg;
  reg        buf_rd_reg, buf_wr_reg;
  // both mac-side loops share this buffer; only the host-side loop can quiet the line
  wire mac_loop = host_side_loop_en | port_loop_en;
  wire rx_to_host = ~(far_end_loop_en & far_loop_rx_withhold);
  wire in_valid = mac_loop ? mac_tx_valid : (rx_to_host & phy_rx_valid);
  wire [DW:0] in_word = mac_loop ? {mac_tx_last, mac_tx_data} : {phy_rx_last, phy_rx_data};
  wire buf_ready = (buf_cnt_reg != 2'h2);
  assign mac_tx_ready = frame_gen_enable ? 1'b0 : mac_loop ? buf_ready : phy_tx_ready;
  wire push = in_valid & buf_ready;
  wire pop  = host_rx_valid & host_rx_ready;
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      buf_cnt_reg <= 2'h0;
      buf_rd_reg <= 1'b0;
      buf_wr_reg <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        buf_reg[buf_wr_reg] <= in_word;
        buf_wr_reg <= ~buf_wr_reg;
      end
      if (pop)
        buf_rd_reg <= ~buf_rd_reg;
      buf_cnt_reg <= buf_cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
  always @*
  begin
    host_rx_valid = (buf_cnt_reg != 2'h0);
    {host_rx_last, host_rx_data} = buf_reg[buf_rd_reg];
  end

  // frame checker
  // counters wrap silently; the host must read them before they overflow
  reg [2*CW-1:0] frames_reg;
  reg [CW-1:0]   crc_cnt_reg;
  reg [8*CW-1:0] err_cnt_reg;
  wire chk_v = frame_chk_source_sel ? push & in_word[DW] & mac_loop
                                    : phy_rx_valid & phy_rx_last;
  wire chk_crc = ~frame_chk_source_sel & phy_rx_crc_err;
  integer k;
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      frames_reg <= {2*CW{1'b0}};
      crc_cnt_reg <= {CW{1'b0}};
      err_cnt_reg <= {8*CW{1'b0}};
      crc_error_counter <= {CW{1'b0}};
      latched_frames_high <= {CW{1'b0}};
      latched_frames_low <= {CW{1'b0}};
      latched_err_counts <= {8*CW{1'b0}};
    end
    else
    begin
      if (frame_chk_enable && chk_v)
      begin
        frames_reg <= frames_reg + {{(2*CW-1){1'b0}}, 1'b1};
        if (chk_crc)
          crc_cnt_reg <= crc_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
      end
      // error kinds include the false carrier strobe, one per bad delimiter entry
      for (k = 0; k < 8; k = k + 1)
        if (frame_chk_enable && phy_rx_err_kinds[k] && !frame_chk_source_sel)
          err_cnt_reg[k*CW +: CW] <= err_cnt_reg[k*CW +: CW] + {{(CW-1){1'b0}}, 1'b1};
      if (crc_counter_rd)
      begin
        crc_error_counter <= crc_cnt_reg;
        latched_frames_high <= frames_reg[2*CW-1:CW];
        latched_frames_low <= frames_reg[CW-1:0];
        latched_err_counts <= err_cnt_reg;
      end
    end
  end
endmodule

// >>> rtl/pld_diag_map.vh
// constants for the link status, loopback and diagnostics block
// Behaviour
// - negotiation done flag set after exchange
// - done-with-link only when negotiated and up
// - link status latches low until read
// - link drop restarts negotiation automatically
// - host restart request restarts negotiation
// - medium loopback needs forced mode, no negotiation
// - coding loopback returns data, line quiet; the code only quiets the line and returns no data
// - host-side loopback returns host data
// - host loopback quiets line; set at reset
// - far-end loopback returns partner data
// - far loopback withholds data; set at reset
// - port loop returns MAC transmit data
// - generator replaces MAC on transmit path
// - generator sends count, then sets finished
// - checker runs on selected source
// - crc counter read latches all counters
// - checker counts frames and error kinds
// - test modes one and two patterns
// - test mode three sends normal idle
// - transmit-disable sends only zero symbols
`ifndef PLD_DIAG_MAP_VH
`define PLD_DIAG_MAP_VH
`define PLD_TM_NORMAL   3'h0
`define PLD_TM_ONE      3'h1
`define PLD_TM_TWO      3'h2
`define PLD_TM_THREE    3'h3
`define PLD_TM_TXDIS    3'h4
`define PLD_SYM_ZERO    2'h0
`define PLD_SYM_PLUS    2'h1
`define PLD_SYM_MINUS   2'h3
`define PLD_TM2_RUN     5'h0A
`define PLD_QUIET_RST   1'h1
`define PLD_WITHHOLD_RST 1'h1
`define PLD_LINK_RST    1'h0
`endif

// >>> testbench/pld_diag_properties.sv
// port assertions for the diagnostics block
`timescale 1ns/1ps
`include "pld_diag_map.vh"
module pld_diag_properties (
  input logic       clock,
  input logic       rst_n,
  input logic       neg_enable,
  input logic       neg_forced_mode,
  input logic       neg_restart_req,
  input logic       neg_restart_pulse,
  input logic       neg_exchange_done,
  input logic       neg_done_with_link,
  input logic       link_status_rd,
  input logic       link_up_latch_low,
  input logic       soft_power_down,
  input logic [2:0] test_pattern_select,
  input logic [1:0] tx_symbol,
  input logic       medium_attach_loop_en,
  input logic       medium_loop_active,
  input logic       coding_sublayer_loop_en,
  input logic       line_drive_en,
  input logic       host_side_loop_en,
  input logic       host_loop_line_quiet,
  input logic       frame_gen_enable,
  input logic       frame_gen_finished,
  input logic       mac_tx_ready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_DONE_LINK: assert property (neg_done_with_link |-> neg_exchange_done)
    else $error("done with link without exchange done");
  AST_LATCH_LOW: assert property (
    !link_up_latch_low && !link_status_rd |=> !link_up_latch_low)
    else $error("link status rose without a read");
  AST_RESTART: assert property (
    neg_enable && $rose(neg_restart_req) |-> ##[0:2] neg_restart_pulse)
    else $error("restart request ignored");
  AST_MEDIUM: assert property (
    medium_loop_active == (medium_attach_loop_en && !neg_enable && neg_forced_mode))
    else $error("medium loop active outside forced mode");
  AST_PCS_QUIET: assert property (coding_sublayer_loop_en |-> !line_drive_en)
    else $error("line driven in coding loopback");
  AST_HOST_QUIET: assert property (host_side_loop_en && host_loop_line_quiet |-> !line_drive_en)
    else $error("line driven in quiet host loopback");
  AST_GEN_OWNS: assert property (frame_gen_enable [*2] |-> !mac_tx_ready)
    else $error("mac accepted while generator runs");
  AST_TM1: assert property (
    (test_pattern_select == `PLD_TM_ONE && !soft_power_down) [*3] ##0
    tx_symbol == `PLD_SYM_PLUS |=> tx_symbol == `PLD_SYM_MINUS)
    else $error("mode one pattern broken");
  AST_TXDIS: assert property (
    (test_pattern_select == `PLD_TM_TXDIS) [*2] |-> tx_symbol == `PLD_SYM_ZERO)
    else $error("nonzero symbol in transmit disable");
  AST_FIN_HOLD: assert property (frame_gen_finished && frame_gen_enable |=> frame_gen_finished)
    else $error("finished dropped while enabled");
  AST_FIN_CLEAR: assert property (!frame_gen_enable [*2] |-> !frame_gen_finished)
    else $error("finished kept after disable");
  cover property ($rose(frame_gen_finished));
  cover property (neg_restart_pulse);
  cover property ($fell(link_up_latch_low));
endmodule
bind pld_diag pld_diag_properties pld_diag_properties_i (.*);

// >>> testbench/pld_far_sink.sv
// far-end line partner: takes the transmit stream and counts beats
`timescale 1ns/1ps
module pld_far_sink (
  input  logic       clock,
  input  logic       stall,
  input  logic       phy_tx_valid,
  input  logic       phy_tx_last,
  input  logic [7:0] phy_tx_data,
  output logic       phy_tx_ready,
  output int         beats,
  output int         frames,
  output int         ones
);
  logic tog = 1'b0;
  always @(posedge clock) tog <= ~tog;
  // a stalling far end takes every other cycle only, to exercise backpressure
  assign phy_tx_ready = stall ? tog : 1'b1;
  // counts start at zero; frames by end marks, ones by all-ones words
  always @(posedge clock)
    if (phy_tx_valid && phy_tx_ready)
    begin
      beats  <= beats + 1;
      frames <= frames + (phy_tx_last ? 1 : 0);
      ones   <= ones + ((phy_tx_data == 8'hFF) ? 1 : 0);
    end
endmodule

// >>> testbench/test_phy_link_status_loopback_diagnostics.sv
// self-checking bench for the link status, loopback and diagnostics block
`timescale 1ns/1ps
`include "pld_diag_map.vh"
module test_phy_link_status_loopback_diagnostics;
  logic clock, rst_n, neg_enable, neg_forced_mode, neg_restart_req, neg_exchange_in, link_ok_in;
  logic neg_restart_pulse, neg_exchange_done, neg_done_with_link, link_status_rd;
  logic link_up_latch_low, soft_power_down, tx_symbol_en, medium_attach_loop_en;
  logic coding_sublayer_loop_en, host_side_loop_en, host_loop_line_quiet, far_end_loop_en;
  logic far_loop_rx_withhold, port_loop_en, medium_loop_active, line_drive_en, mac_tx_valid;
  logic mac_tx_last, mac_tx_ready, host_rx_valid, host_rx_last, host_rx_ready, phy_rx_valid;
  logic phy_rx_last, phy_rx_crc_err, phy_tx_valid, phy_tx_last, phy_tx_ready, frame_gen_enable;
  logic frame_gen_random, frame_gen_finished, frame_chk_enable, frame_chk_source_sel;
  logic crc_counter_rd, stall;
  logic [2:0]   test_pattern_select;
  logic [1:0]   tx_symbol;
  logic [7:0]   mac_tx_data, host_rx_data, phy_rx_data, phy_tx_data, phy_rx_err_kinds;
  logic [15:0]  frame_gen_length, frame_gen_count, crc_error_counter;
  logic [15:0]  latched_frames_high, latched_frames_low;
  logic [127:0] latched_err_counts;
  int           errors, checked, beats, frames, ones, cyc, i;
  pld_diag pld_diag_i (.*);
  pld_far_sink pld_far_sink_i (.*);
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task step(input int n = 1);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task chk(input logic [127:0] seen, input logic [127:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task rd_link;
    link_status_rd = 1'b1;
    step();
    link_status_rd = 1'b0;
  endtask
  // request held until ready was seen settled, so the next edge takes it;
  // valid stays up for back-to-back calls, the caller lowers it afterwards
  task push(input logic [7:0] d);
    {mac_tx_data, mac_tx_last, mac_tx_valid} = {d, 2'h3};
    while (mac_tx_ready !== 1'b1) step();
    step();
  endtask
  task rx_frame(input logic bad);
    {phy_rx_valid, phy_rx_data} = {1'b1, 8'h55};
    step();
    {phy_rx_last, phy_rx_crc_err} = {1'b1, bad};
    step();
    {phy_rx_valid, phy_rx_last, phy_rx_crc_err} = 3'h0;
    step();
  endtask
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      close_out();
    end
  end
  initial
  begin
    {neg_forced_mode, neg_restart_req, neg_exchange_in, link_ok_in, link_status_rd} = '0;
    {soft_power_down, medium_attach_loop_en, coding_sublayer_loop_en, host_side_loop_en} = '0;
    {far_end_loop_en, port_loop_en, mac_tx_valid, mac_tx_last, host_rx_ready} = '0;
    {phy_rx_valid, phy_rx_last, phy_rx_crc_err, frame_gen_enable, frame_gen_random} = '0;
    {frame_chk_enable, frame_chk_source_sel, crc_counter_rd, stall} = '0;
    {neg_enable, host_loop_line_quiet, far_loop_rx_withhold} = 3'h7;
    {test_pattern_select, mac_tx_data, phy_rx_data, phy_rx_err_kinds} = '0;
    {frame_gen_length, frame_gen_count} = {16'h0004, 16'h0002};
    rst_n = 1'b0;
    step(10);
    rst_n = 1'b1;
    chk({link_up_latch_low, frame_gen_finished}, 2'h0);
    chk(line_drive_en, 1'b1);
    {link_ok_in, neg_exchange_in} = 2'h3;
    step(6);
    chk({neg_exchange_done, neg_done_with_link, link_up_latch_low}, 3'h6);
    rd_link();
    chk(link_up_latch_low, 1'b1);
    link_ok_in = 1'b0;
    step(3);
    chk(neg_restart_pulse, 1'b1);
    step(3);
    chk({neg_done_with_link, link_up_latch_low}, 2'h0);
    link_ok_in = 1'b1;
    step(6);
    chk(link_up_latch_low, 1'b0);
    rd_link();
    chk(link_up_latch_low, 1'b1);
    neg_restart_req = 1'b1;
    step();
    chk(neg_restart_pulse, 1'b1);
    {neg_restart_req, host_side_loop_en} = 2'h1;
    step();
    chk(line_drive_en, 1'b0);
    push(8'hA0);
    push(8'hA1);
    chk(mac_tx_ready, 1'b0);
    mac_tx_valid = 1'b0;
    host_rx_ready = 1'b1;
    for (i = 0; i < 2; i++)
    begin
      while (host_rx_valid !== 1'b1) step();
      chk(host_rx_data, 8'hA0 + i);
      chk(host_rx_last, 1'b1);
      step();
    end
    {host_side_loop_en, coding_sublayer_loop_en} = 2'h1;
    step();
    chk(line_drive_en, 1'b0);
    {coding_sublayer_loop_en, stall, frame_gen_enable} = 3'h3;
    step();
    chk(mac_tx_ready, 1'b0);
    while (frame_gen_finished !== 1'b1) step();
    chk(beats, 8);
    chk(frames, 2);
    chk(ones, 8);
    step(3);
    chk(frame_gen_finished, 1'b1);
    frame_gen_enable = 1'b0;
    step(2);
    chk(frame_gen_finished, 1'b0);
    frame_gen_enable = 1'b1;
    while (frame_gen_finished !== 1'b1) step();
    chk(beats, 16);
    frame_gen_enable = 1'b0;
    step();
    frame_chk_enable = 1'b1;
    for (i = 0; i < 3; i++) rx_frame(i < 2);
    phy_rx_err_kinds = 8'hFF;
    step();
    {phy_rx_err_kinds, crc_counter_rd} = 9'h001;
    step();
    crc_counter_rd = 1'b0;
    step();
    chk(crc_error_counter, 2);
    chk({latched_frames_high, latched_frames_low}, 3);
    chk(latched_err_counts, {8{16'h0001}});
    {port_loop_en, frame_chk_source_sel} = 2'h3;
    step();
    push(8'h5A);
    mac_tx_valid = 1'b0;
    chk({host_rx_valid, host_rx_data}, 9'h15A);
    crc_counter_rd = 1'b1;
    step();
    crc_counter_rd = 1'b0;
    step();
    chk({latched_frames_high, latched_frames_low}, 4);
    {port_loop_en, frame_chk_source_sel, frame_chk_enable} = 3'h0;
    {far_end_loop_en, phy_rx_valid, phy_rx_last, phy_rx_data} = {3'h7, 8'h3C};
    step();
    chk({phy_tx_valid, phy_tx_last, phy_tx_data}, 10'h33C);
    chk(host_rx_valid, 1'b0);
    far_loop_rx_withhold = 1'b0;
    step();
    chk(host_rx_valid, 1'b1);
    {far_end_loop_en, phy_rx_valid, phy_rx_last, far_loop_rx_withhold} = 4'h1;
    soft_power_down = 1'b1;
    step();
    {neg_enable, neg_forced_mode, medium_attach_loop_en} = 3'h3;
    step();
    chk(medium_loop_active, 1'b1);
    test_pattern_select = `PLD_TM_ONE;
    soft_power_down = 1'b0;
    step(8);
    chk({tx_symbol_en, tx_symbol}, {1'b1, `PLD_SYM_MINUS});
    test_pattern_select = `PLD_TM_TWO;
    step(25);
    while (tx_symbol !== `PLD_SYM_MINUS) step();
    while (tx_symbol !== `PLD_SYM_PLUS) step();
    for (i = 0; i < 20; i++)
    begin
      chk(tx_symbol, i < 10 ? `PLD_SYM_PLUS : `PLD_SYM_MINUS);
      step();
    end
    test_pattern_select = `PLD_TM_TXDIS;
    step(3);
    chk({tx_symbol_en, tx_symbol}, {1'b1, `PLD_SYM_ZERO});
    test_pattern_select = `PLD_TM_THREE;
    step(2);
    chk(tx_symbol_en, 1'b0);
    rst_n = 1'b0;
    step(2);
    chk({neg_exchange_done, link_up_latch_low, host_rx_valid}, 3'h0);
    rst_n = 1'b1;
    step(2);
    chk(link_up_latch_low, 1'b0);
    close_out();
  end
endmodule
